// *** verif/bus_isolation_reset_wake_control_test.sv ***
// Self-checking testbench for the isolation, reset and wake control block.
`timescale 1ns/1ns
module bus_isolation_reset_wake_control_test;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic rst_req = 1'b0;
    logic tie_mode = 1'b0;
    logic bus_rst_n;
    logic isolate_n;
    pm_wake_pkg::pm_ctrl_t pm_ctrl = '0;
    logic bar_write = 1'b0;
    logic cfg_access = 1'b0;
    logic mem_access = 1'b0;
    logic mac_cfg_wr = 1'b0;
    logic mac_cfg_wake = 1'b0;
    logic link_valid = 1'b1;
    logic pattern_hit = 1'b0;
    logic [pm_wake_pkg::MATCH_IDX_W:0] match_byte_idx = 8'h00;
    logic init_pulse;
    logic bus_out_en_n;
    logic pme_n_o;
    logic pme_n_oe_n;
    logic access_grant;
    pm_wake_pkg::feature_t features;
    logic [1:0] pm_state_code;
    logic wake_en_out;
    logic pme_status_out;
    int fails = 0;
    int checks = 0;
    int cnt;

    host_bus_model i_host (.rst_req(rst_req), .tie_mode(tie_mode), .bus_rst_n(bus_rst_n),
        .isolate_n(isolate_n));
    bus_isolation_reset_wake_control i_dut (.clock(clock), .sys_rst(sys_rst),
        .bus_rst_n(bus_rst_n), .isolate_n(isolate_n), .pm_ctrl(pm_ctrl),
        .bar_write(bar_write), .cfg_access(cfg_access), .mem_access(mem_access),
        .mac_cfg_wr(mac_cfg_wr), .mac_cfg_wake(mac_cfg_wake), .link_valid(link_valid),
        .pattern_hit(pattern_hit), .match_byte_idx(match_byte_idx), .init_pulse(init_pulse),
        .bus_out_en_n(bus_out_en_n), .pme_n_o(pme_n_o), .pme_n_oe_n(pme_n_oe_n),
        .access_grant(access_grant), .features(features), .pm_state_code(pm_state_code),
        .wake_en_out(wake_en_out), .pme_status_out(pme_status_out));

    // ----------------------------------------
    // Clock and shared tasks
    // ----------------------------------------
    initial
    begin
        forever #2 clock = ~clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Counts the cycles with the initialization pulse high over a span.
    task automatic count_init(input int n);
        cnt = 0;
        repeat (n)
        begin
            cyc(1);
            if (init_pulse === 1'b1)
                cnt++;
        end
    endtask

    task automatic do_reset();
        @(posedge clock);
        sys_rst <= 1'b1;
        rst_req <= 1'b0;
        tie_mode <= 1'b0;
        link_valid <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        cyc(8);
    endtask

    task automatic pm_write(input logic [1:0] st, input logic we, input logic clr);
        @(posedge clock);
        pm_ctrl <= '{wr: 1'b1, state: st, wake_en: we, status_clr: clr};
        @(posedge clock);
        pm_ctrl <= '0;
        cyc(1);
    endtask

    task automatic bar_init();
        @(posedge clock);
        bar_write <= 1'b1;
        @(posedge clock);
        bar_write <= 1'b0;
        cyc(1);
    endtask

    task automatic mac_set(input logic wk);
        @(posedge clock);
        mac_cfg_wr <= 1'b1;
        mac_cfg_wake <= wk;
        @(posedge clock);
        mac_cfg_wr <= 1'b0;
        cyc(1);
    endtask

    task automatic link_to(input logic v);
        @(posedge clock);
        link_valid <= v;
        cyc(3);
    endtask

    task automatic hit(input logic [7:0] idx);
        @(posedge clock);
        pattern_hit <= 1'b1;
        match_byte_idx <= idx;
        @(posedge clock);
        pattern_hit <= 1'b0;
        cyc(2);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_wake();
        do_reset();
        bar_init();
        check(8'(features.full_func), 8'h01);
        pm_write(pm_wake_pkg::PS_REQ_D0, 1'b1, 1'b0);
        mac_set(1'b1);
        link_to(1'b0);
        check({6'h0, pme_status_out, pme_n_oe_n}, 8'h02);
        link_to(1'b1);
        pm_write(pm_wake_pkg::PS_REQ_D1, 1'b1, 1'b1);
        check({3'h0, pm_state_code, wake_en_out, features.cfg_only, pme_n_oe_n}, 8'h0f);
        check(8'(features.match_en), 8'h01);
        @(posedge clock);
        cfg_access <= 1'b1;
        @(posedge clock);
        cfg_access <= 1'b0;
        mem_access <= 1'b1;
        #1;
        check(8'(access_grant), 8'h01);
        @(posedge clock);
        mem_access <= 1'b0;
        #1;
        check(8'(access_grant), 8'h00);
        hit(8'h80);
        check(8'(pme_status_out), 8'h00);
        hit(8'h7f);
        check({6'h0, pme_status_out, pme_n_oe_n}, 8'h02);
        check(8'(pme_n_o), 8'h00);
        pm_write(pm_wake_pkg::PS_REQ_D1, 1'b1, 1'b1);
        link_to(1'b0);
        check({6'h0, pme_status_out, pme_n_oe_n}, 8'h02);
        pm_write(pm_wake_pkg::PS_REQ_D1, 1'b1, 1'b1);
        link_to(1'b1);
        check({6'h0, pme_status_out, pme_n_oe_n}, 8'h02);
        $display("test wake done");
    endtask

    task automatic t_gating();
        do_reset();
        bar_init();
        pm_write(pm_wake_pkg::PS_REQ_D1, 1'b1, 1'b0);
        link_to(1'b0);
        check({6'h0, pme_status_out, pme_n_oe_n}, 8'h03);
        pm_write(pm_wake_pkg::PS_REQ_D2, 1'b0, 1'b1);
        mac_set(1'b1);
        link_to(1'b1);
        check({6'h0, pme_status_out, pme_n_oe_n}, 8'h01);
        check({6'h0, features.cfg_only, features.link_keep}, 8'h03);
        pm_write(pm_wake_pkg::PS_REQ_D2, 1'b1, 1'b0);
        link_to(1'b0);
        check({6'h0, features.link_watch, features.link_keep}, 8'h02);
        $display("test gating done");
    endtask

    task automatic t_bus_reset();
        do_reset();
        bar_init();
        pm_write(pm_wake_pkg::PS_REQ_D1, 1'b1, 1'b0);
        link_to(1'b0);
        @(posedge clock);
        rst_req <= 1'b1;
        cyc(8);
        count_init(20);
        check(8'(cnt), 8'h14);
        @(posedge clock);
        rst_req <= 1'b0;
        cyc(10);
        check({5'h0, init_pulse, wake_en_out, pme_status_out}, 8'h03);
        bar_init();
        pm_write(pm_wake_pkg::PS_REQ_D3, 1'b1, 1'b0);
        @(posedge clock);
        rst_req <= 1'b1;
        count_init(20);
        check(8'(cnt), 8'h00);
        @(posedge clock);
        rst_req <= 1'b0;
        count_init(15);
        check(8'(cnt), 8'(pm_wake_pkg::INIT_PULSE_CYC));
        $display("test bus reset done");
    endtask

    task automatic t_isolate();
        do_reset();
        bar_init();
        @(posedge clock);
        tie_mode <= 1'b1;
        rst_req <= 1'b1;
        cyc(8);
        pm_write(pm_wake_pkg::PS_REQ_D2, 1'b1, 1'b0);
        check({5'h0, bus_out_en_n, pm_state_code}, 8'h04);
        @(posedge clock);
        rst_req <= 1'b0;
        count_init(15);
        check(8'(cnt), 8'(pm_wake_pkg::INIT_PULSE_CYC));
        check(8'(bus_out_en_n), 8'h00);
        $display("test isolate done");
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (11) @(posedge clock);
        #1;
        check({init_pulse, bus_out_en_n, pme_n_oe_n, access_grant, pm_state_code,
            wake_en_out, pme_status_out}, 8'he0);
        check({2'h0, pme_n_o, features}, 8'h20);
        @(posedge clock);
        sys_rst <= 1'b0;
        cyc(8);
        check({6'h0, init_pulse, bus_out_en_n}, 8'h00);
        $display("test reset done");
        t_wake();
        t_gating();
        t_bus_reset();
        t_isolate();
        tally_and_finish();
    end

    initial
    begin
        repeat (5000) @(posedge clock);
        fails++;
        tally_and_finish();
    end
endmodule // bus_isolation_reset_wake_control_test

// *** verif/host_bus_model.sv ***
// Host side model: drives the bus reset and isolate pins of the block.
`timescale 1ns/1ns
module host_bus_model
(
    // Commands from the bench
    input wire logic rst_req,
    input wire logic tie_mode,
    // Bus pins, active low
    output logic bus_rst_n,
    output logic isolate_n
);
    // A wired host ties isolate to bus reset; an older host keeps it high.
    assign bus_rst_n = ~rst_req;
    assign isolate_n = tie_mode ? ~rst_req : 1'b1;
endmodule // host_bus_model

// *** verilog/bus_isolation_reset_wake_control.sv ***
// Bus isolation, internal initialization, power state features and wake signalling.
//
// Overview of operation
// RL1 - While isolate is low, ignore bus inputs and float bus outputs except wake.
// RL2 - Isolate rising, bus returning to full power, produces an initialization pulse.
// RL3 - Host ties isolate to bus reset, low whenever bus power is off.
// RL4 - Active bus reset in D0, D1 or D2 raises initialization.
// RL5 - In D3 only the rising edge of bus reset raises initialization.
// RL6 - Bus reset rising edge marks the bus returning to full power.
// RL7 - Initialization clears configuration, MAC setup and memory structure state.
// RL8 - With wake enabled, bus reset keeps power registers and wake pattern.
// RL9 - In active D0, full operation; wake on any link change.
// RL10 - D1 link valid: config access only, wake on match or link loss.
// RL11 - D2 and D3 with power behave like D1 while link valid.
// RL12 - D2, D3 with link invalid: only watch for link, no integrity.
// RL13 - Wake events only while wake enable is set.
// RL14 - Pattern matcher covers the first 128 bytes of a frame.
// RL15 - Link change is reported in every power state.
// RL16 - Wake output is gated by wake enable and MAC configure setting.
// RL17 - First base address write moves uninitialized D0 to active D0.
// RL18 - A wake event in low power asserts the wake output.
// RL19 - Isolate and bus reset are synchronised; each edge gives one pulse.
`timescale 1ns/1ns
module bus_isolation_reset_wake_control
(
    // Clock and power-on reset
    input wire logic clock,
    input wire logic sys_rst,
    // Bus pins, active low
    input wire logic bus_rst_n,
    input wire logic isolate_n,
    // Host power management and configuration events
    input wire pm_wake_pkg::pm_ctrl_t pm_ctrl,
    input wire logic bar_write,
    input wire logic cfg_access,
    input wire logic mem_access,
    // MAC configure command setting for wake output
    input wire logic mac_cfg_wr,
    input wire logic mac_cfg_wake,
    // Link and packet matcher
    input wire logic link_valid,
    input wire logic pattern_hit,
    input wire logic [pm_wake_pkg::MATCH_IDX_W:0] match_byte_idx,
    // Outputs
    output logic init_pulse,
    output logic bus_out_en_n,
    output logic pme_n_o,
    output logic pme_n_oe_n,
    output logic access_grant,
    output pm_wake_pkg::feature_t features,
    output logic [1:0] pm_state_code,
    output logic wake_en_out,
    output logic pme_status_out
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic rst_lvl, rst_rise, iso_lvl, iso_rise;

    pin_sync u_rst_sync
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin(bus_rst_n),
        .level(rst_lvl),
        .rise(rst_rise),
        .fall()
    ); // [RL19]

    pin_sync u_iso_sync
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin(isolate_n),
        .level(iso_lvl),
        .rise(iso_rise),
        .fall()
    ); // [RL19]

    // ------------------------------------------------------------
    // Power state and control
    // ------------------------------------------------------------
    pm_wake_pkg::pstate_t ps_q, ps_d;
    logic wake_en_q, wake_en_d, mac_wake_q, mac_wake_d;
    logic pme_st_q, pme_st_d, link_q, link_d;
    logic [1:0] init_cnt_q, init_cnt_d;
    logic iso_act, rst_act, init_req, wake_ev, link_chg, low_pwr, hit_ok;
    logic bus_in_ok;

    assign iso_act = ~iso_lvl;
    assign rst_act = ~rst_lvl;
    assign bus_in_ok = ~iso_act; // [RL1]
    assign low_pwr = (ps_q != pm_wake_pkg::PS_D0U) && (ps_q != pm_wake_pkg::PS_D0A);
    assign link_chg = link_valid != link_q; // [RL15]
    assign hit_ok = pattern_hit && (match_byte_idx < 8'(pm_wake_pkg::MATCH_BYTES)); // [RL14]

    always_comb
    begin
        // Bus reset held in D0..D2, its trailing edge in D3, and isolate rising.
        init_req = iso_rise; // [RL2]
        if (bus_in_ok)
        begin
            if (ps_q == pm_wake_pkg::PS_D3)
            begin
                init_req = init_req | rst_rise; // [RL5] [RL6]
            end
            else
            begin
                init_req = init_req | rst_act; // [RL4]
            end
        end
    end

    always_comb
    begin
        wake_ev = 1'b0;
        case (ps_q)
            pm_wake_pkg::PS_D0U, pm_wake_pkg::PS_D0A: wake_ev = link_chg; // [RL9] [RL15]
            pm_wake_pkg::PS_D1: wake_ev = link_q ? (hit_ok | ~link_valid) : link_valid; // [RL10]
            pm_wake_pkg::PS_D2, pm_wake_pkg::PS_D3:
                wake_ev = link_q ? (hit_ok | ~link_valid) : link_valid; // [RL11] [RL12]
            default: wake_ev = 1'b0;
        endcase
        wake_ev = wake_ev & wake_en_q; // [RL13]
    end

    always_comb
    begin
        ps_d = ps_q;
        wake_en_d = wake_en_q;
        mac_wake_d = mac_wake_q;
        pme_st_d = pme_st_q;
        link_d = link_valid;
        init_cnt_d = (init_cnt_q != 2'h0) ? init_cnt_q - 2'h1 : 2'h0;
        if (init_req)
        begin
            init_cnt_d = 2'(pm_wake_pkg::INIT_PULSE_CYC);
            ps_d = pm_wake_pkg::PS_D0U; // [RL7]
            mac_wake_d = 1'b0;
            if (!wake_en_q)
            begin
                pme_st_d = pm_wake_pkg::RST_PME_STATUS; // [RL8]
            end
        end
        else if (bus_in_ok)
        begin
            if (bar_write && ps_q == pm_wake_pkg::PS_D0U)
            begin
                ps_d = pm_wake_pkg::PS_D0A; // [RL17]
            end
            if (pm_ctrl.wr)
            begin
                wake_en_d = pm_ctrl.wake_en;
                if (pm_ctrl.status_clr)
                begin
                    pme_st_d = 1'b0;
                end
                case (pm_ctrl.state)
                    pm_wake_pkg::PS_REQ_D0:
                        if (low_pwr) ps_d = pm_wake_pkg::PS_D0A;
                    pm_wake_pkg::PS_REQ_D1: ps_d = pm_wake_pkg::PS_D1;
                    pm_wake_pkg::PS_REQ_D2: ps_d = pm_wake_pkg::PS_D2;
                    pm_wake_pkg::PS_REQ_D3: ps_d = pm_wake_pkg::PS_D3;
                    default: ps_d = ps_q;
                endcase
            end
            if (mac_cfg_wr)
            begin
                mac_wake_d = mac_cfg_wake;
            end
        end
        if (wake_ev)
        begin
            pme_st_d = 1'b1; // set wins over clear
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ps_q <= pm_wake_pkg::PS_D0U;
            wake_en_q <= pm_wake_pkg::RST_WAKE_EN;
            mac_wake_q <= 1'b0;
            pme_st_q <= pm_wake_pkg::RST_PME_STATUS;
            link_q <= 1'b0;
            init_cnt_q <= 2'h0;
        end
        else
        begin
            ps_q <= ps_d;
            wake_en_q <= wake_en_d;
            mac_wake_q <= mac_wake_d;
            pme_st_q <= pme_st_d;
            link_q <= link_d;
            init_cnt_q <= init_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    pm_wake_pkg::feature_t feat_d;
    logic grant_d, pme_n_d;

    always_comb
    begin
        feat_d = '0;
        feat_d.full_func = (ps_d == pm_wake_pkg::PS_D0A);
        feat_d.cfg_only = (ps_d == pm_wake_pkg::PS_D1) || (ps_d == pm_wake_pkg::PS_D2)
            || (ps_d == pm_wake_pkg::PS_D3);
        feat_d.link_keep = feat_d.full_func || (ps_d == pm_wake_pkg::PS_D1)
            || ((ps_d == pm_wake_pkg::PS_D2) && link_valid)
            || ((ps_d == pm_wake_pkg::PS_D3) && link_valid && wake_en_d); // [RL11] [RL12]
        feat_d.link_watch = feat_d.cfg_only && wake_en_d;
        feat_d.match_en = feat_d.cfg_only && link_valid && wake_en_d; // [RL14]
        grant_d = bus_in_ok && (cfg_access || (mem_access && !feat_d.cfg_only)); // [RL10]
        pme_n_d = ~(pme_st_d & wake_en_d & mac_wake_d); // [RL16] [RL18]
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            init_pulse <= 1'b1;
            bus_out_en_n <= 1'b1;
            pme_n_o <= 1'b1;
            pme_n_oe_n <= 1'b1;
            access_grant <= 1'b0;
            features <= '0;
            pm_state_code <= pm_wake_pkg::PS_REQ_D0;
            wake_en_out <= pm_wake_pkg::RST_WAKE_EN;
            pme_status_out <= pm_wake_pkg::RST_PME_STATUS;
        end
        else
        begin
            init_pulse <= (init_cnt_d != 2'h0); // [RL7]
            bus_out_en_n <= iso_act; // [RL1]
            pme_n_o <= 1'b0;
            pme_n_oe_n <= pme_n_d; // open drain stays active while isolated
            access_grant <= grant_d;
            features <= feat_d;
            pm_state_code <= (ps_d == pm_wake_pkg::PS_D1) ? pm_wake_pkg::PS_REQ_D1 :
                (ps_d == pm_wake_pkg::PS_D2) ? pm_wake_pkg::PS_REQ_D2 :
                (ps_d == pm_wake_pkg::PS_D3) ? pm_wake_pkg::PS_REQ_D3 : pm_wake_pkg::PS_REQ_D0;
            wake_en_out <= wake_en_d;
            pme_status_out <= pme_st_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_iso_float;
        @(posedge clock) disable iff (sys_rst) iso_act |=> bus_out_en_n;
    endproperty
    a_iso_float: assert property (p_iso_float) else $error("bus outputs not floated"); // [RL1]

    property p_iso_init;
        @(posedge clock) disable iff (sys_rst) iso_rise |=> init_pulse [*2];
    endproperty
    a_iso_init: assert property (p_iso_init) else $error("no init after isolate"); // [RL2]

    property p_rst_d0;
        @(posedge clock) disable iff (sys_rst)
            (rst_act && bus_in_ok && ps_q != pm_wake_pkg::PS_D3) |=> init_pulse;
    endproperty
    a_rst_d0: assert property (p_rst_d0) else $error("no init on bus reset"); // [RL4]

    property p_d3_level;
        @(posedge clock) disable iff (sys_rst)
            (ps_q == pm_wake_pkg::PS_D3 && !rst_rise && !iso_rise && init_cnt_q == 2'h0)
            |=> !init_pulse;
    endproperty
    a_d3_level: assert property (p_d3_level) else $error("init during D3 reset level"); // [RL5]

    property p_init_clear;
        @(posedge clock) disable iff (sys_rst) init_req |=> ps_q == pm_wake_pkg::PS_D0U;
    endproperty
    a_init_clear: assert property (p_init_clear) else $error("state not cleared"); // [RL7]

    property p_keep_pme;
        @(posedge clock) disable iff (sys_rst)
            (init_req && wake_en_q && pme_st_q) |=> pme_st_q && wake_en_q;
    endproperty
    a_keep_pme: assert property (p_keep_pme) else $error("pm state lost"); // [RL8]

    property p_no_wake;
        @(posedge clock) disable iff (sys_rst) (!wake_en_q && !pme_st_q) |=> !pme_st_q;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("wake without enable"); // [RL13]

    property p_pme_gate;
        @(posedge clock) disable iff (sys_rst) !pme_n_oe_n |-> wake_en_out && pme_status_out;
    endproperty
    a_pme_gate: assert property (p_pme_gate) else $error("wake output ungated"); // [RL16]

    property p_bar;
        @(posedge clock) disable iff (sys_rst)
            (bar_write && bus_in_ok && !init_req && !pm_ctrl.wr && ps_q == pm_wake_pkg::PS_D0U)
            |=> ps_q == pm_wake_pkg::PS_D0A;
    endproperty
    a_bar: assert property (p_bar) else $error("no move to active D0"); // [RL17]
endmodule // bus_isolation_reset_wake_control

// *** verilog/pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter and edge detection.
`timescale 1ns/1ns
module pin_sync
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Pin and filtered result
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1_q, s2_q, s3_q, lvl_q;
    logic lvl_d;

    always_comb
    begin
        lvl_d = (s2_q == s3_q) ? s2_q : lvl_q;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            lvl_q <= 1'b1;
        end
        else
        begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q;
    assign rise = lvl_d & ~lvl_q;
    assign fall = ~lvl_d & lvl_q;
endmodule // pin_sync

// *** verilog/pm_wake_pkg.sv ***
// Shared types and constants for the bus isolation, reset and wake control block.
package pm_wake_pkg;

    // Device power states, one-hot.
    typedef enum logic [4:0] {
        PS_D0U = 5'h01,
        PS_D0A = 5'h02,
        PS_D1 = 5'h04,
        PS_D2 = 5'h08,
        PS_D3 = 5'h10
    } pstate_t;

    // Power state request codes as software writes them in the control/status register.
    localparam logic [1:0] PS_REQ_D0 = 2'h0;
    localparam logic [1:0] PS_REQ_D1 = 2'h1;
    localparam logic [1:0] PS_REQ_D2 = 2'h2;
    localparam logic [1:0] PS_REQ_D3 = 2'h3;

    // Width of the window the packet matcher looks into, and the top bit of its index.
    localparam int MATCH_BYTES = 128;
    localparam int MATCH_IDX_W = 7;

    // Initialization pulse length.
    localparam int INIT_PULSE_NS = 8;
    localparam int CLK_PERIOD_NS = 4;
    localparam int INIT_PULSE_CYC = (INIT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Reset values.
    localparam logic RST_WAKE_EN = 1'b0;
    localparam logic RST_PME_STATUS = 1'b0;

    // Status of the link and power features for the rest of the device.
    typedef struct packed {
        logic cfg_only;
        logic full_func;
        logic link_keep;
        logic link_watch;
        logic match_en;
    } feature_t;

    // Host power management controls.
    typedef struct packed {
        logic wr;
        logic [1:0] state;
        logic wake_en;
        logic status_clr;
    } pm_ctrl_t;

endpackage
